// ---- hw/mcv_pkg.sv ----
/*
 * constants of the transmit configuration vector block: vector widths, field positions,
 * register offsets and reset values. assumes nothing of its surroundings.
 */
package mcv_pkg;
   // vector widths with and without the priority flow control option
   localparam int TX_BASE_W   = 80;
   localparam int TX_PFC_W    = 368;
   localparam int RX_BASE_W   = 80;
   localparam int RX_PFC_W    = 96;
   localparam int FIELD_W     = 16;
   // upper transmit and receive vector field positions (lsb of each field)
   localparam int LEGACY_REFRESH_LSB = 352;
   localparam int PRIO2_QUANTA_LSB   = 160;
   localparam int PRIO2_REFRESH_LSB  = 176;
   localparam int PRIO_STRIDE        = 32;
   localparam int PRIO_ENABLE_BIT0   = 88;
   localparam int RX_PFC_LSB         = 80;
   localparam int PRIO_LO            = 2;
   localparam int PRIO_N             = 6;
   // apb register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LEGACY = 8'h08;
   localparam logic [7:0] REG_RXPFC  = 8'h0C;
   localparam int CTRL_AUTO_RESUME   = 0;
   localparam logic CTRL_RESET       = 1'b0;
   // status field positions
   localparam int ST_HELD    = 0;
   localparam int ST_PAUSE   = 1;
   localparam int ST_XON     = 2;
   localparam int ST_PFC     = 3;
   localparam int ST_ACT_LSB = 8;
   typedef enum logic [1:0] {
      PS_IDLE = 2'b00,
      PS_HELD = 2'b01
   } mcv_pause_e;
endpackage : mcv_pkg

// ---- hw/mcv_tx_cfg.sv ----
/*
 * transmit configuration vector shadow with legacy pause and priority flow control
 * frame request generation, plus a small apb register window.
 * assumes the vectors, request inputs, quanta tick and frame done pulses are driven
 * by logic on the same transmit clock.
 */
// Summary of operation
// - without a management interface all settings arrive on a transmit and a receive vector.
// - vectors may change at any time but only take effect once the current frame has ended.
// - transmit vector bits 367:80 exist only when priority flow control is built in.
// - receive vector bits 95:80 exist only when priority flow control is built in.
// - bits 367:352 give the count at which a held pause request re-sends its pause frame.
// - dropping the pause request sends a resume frame when the automatic resume option is on.
// - each priority quanta field is the value carried in its flow control frame.
// - each priority refresh field is the count at which an active priority re-sends a frame.
// - priority 7 uses refresh bits 351:336 and quanta bits 335:320.
// - priority 6 uses refresh bits 319:304 and quanta bits 303:288.
// - priority 5 uses refresh bits 287:272 and quanta bits 271:256.
// - priority 4 uses refresh bits 255:240 and quanta bits 239:224.
// - priority 3 uses refresh bits 223:208 and quanta bits 207:192.
// - priority 2 uses refresh bits 191:176 and quanta bits 175:160.
// - bit 95 must be set before the priority 7 request can produce frames.
`timescale 1ns/1ps
`default_nettype none
module mcv_tx_cfg
   import mcv_pkg::*;
#(
   parameter bit PFC_PRESENT = 1'b1,
   parameter int TXW         = PFC_PRESENT ? TX_PFC_W : TX_BASE_W,
   parameter int RXW         = PFC_PRESENT ? RX_PFC_W : RX_BASE_W
) (
   input  wire logic                  clock,
   input  wire logic                  nrst,
   input  wire logic [TXW-1:0]        txConfigVector,
   input  wire logic [RXW-1:0]        rxConfigVector,
   input  wire logic                  txFrameActive,
   input  wire logic                  quantaTick,
   input  wire logic                  pauseRequest,
   input  wire logic                  priority7RequestValid,
   input  wire logic [6:2]            priorityRequestValid,
   input  wire logic                  pauseFrameDone,
   input  wire logic                  pfcFrameDone,
   output logic                       pauseFrameReq,
   output logic                       xonFrameReq,
   output logic                       pfcFrameReq,
   output logic [PRIO_N-1:0]          pfcPriorityMask,
   output logic [PRIO_N*FIELD_W-1:0]  pfcQuanta,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr
);

   typedef struct packed {
      mcv_pause_e                        pst;
      logic [FIELD_W-1:0]                pauseCnt;
      logic                              pauseReq;
      logic                              xonReq;
      logic                              pfcReq;
      logic [PRIO_N-1:0]                 pfcMask;
      logic [PRIO_N-1:0]                 prioPrev;
      logic [PRIO_N-1:0][FIELD_W-1:0]    prioCnt;
      logic [FIELD_W-1:0]                shLegacy;
      logic [PRIO_N-1:0][FIELD_W-1:0]    shQuanta;
      logic [PRIO_N-1:0][FIELD_W-1:0]    shRefresh;
      logic [PRIO_N-1:0]                 shEnable;
      logic [FIELD_W-1:0]                shRx;
      logic                              autoResume;
      logic                              pready;
      logic                              pslverr;
      logic [31:0]                       prdata;
   } mcv_state_s;

   mcv_state_s st;
   mcv_state_s next_st;

   // field slices of the live vectors; all zero when the option is absent
   logic [FIELD_W-1:0]              cfgLegacy;
   logic [PRIO_N-1:0][FIELD_W-1:0]  cfgQuanta;
   logic [PRIO_N-1:0][FIELD_W-1:0]  cfgRefresh;
   logic [PRIO_N-1:0]               cfgEnable;
   logic [FIELD_W-1:0]              cfgRx;
   logic [PRIO_N-1:0]               reqValid;

   assign reqValid = {priority7RequestValid, priorityRequestValid};

   generate
      if (PFC_PRESENT) begin : g_pfc
         assign cfgLegacy = txConfigVector[LEGACY_REFRESH_LSB +: FIELD_W];
         assign cfgRx     = rxConfigVector[RX_PFC_LSB +: FIELD_W];
         for (genvar i = 0; i < PRIO_N; i++) begin : g_prio
            // one quanta/refresh pair per priority, 32 bits apart
            assign cfgQuanta[i]  = txConfigVector[PRIO2_QUANTA_LSB + i*PRIO_STRIDE +: FIELD_W];
            assign cfgRefresh[i] = txConfigVector[PRIO2_REFRESH_LSB + i*PRIO_STRIDE +: FIELD_W];
            assign cfgEnable[i]  = txConfigVector[PRIO_ENABLE_BIT0 + PRIO_LO + i];
         end
      end else begin : g_nopfc
         // bits are absent, so the priority frame generators stay quiet
         assign cfgLegacy  = '0;
         assign cfgRx      = '0;
         assign cfgQuanta  = '0;
         assign cfgRefresh = '0;
         assign cfgEnable  = '0;
      end
   endgenerate

   // address decode shared by read mux and error answer
   function automatic logic mcv_hit(input logic [7:0] addr, input logic [7:0] off);
      mcv_hit = (addr == off);
   endfunction : mcv_hit

   logic apbAccess;
   logic apbDone;
   logic mapped;
   assign apbAccess = psel & penable & ~st.pready;
   assign apbDone   = psel & penable & st.pready;
   assign mapped    = mcv_hit(paddr, REG_CTRL) | mcv_hit(paddr, REG_STATUS) |
                      mcv_hit(paddr, REG_LEGACY) | mcv_hit(paddr, REG_RXPFC);

   // next-state logic for bus slave, shadow copy, pause and priority generators
   always_comb begin
      logic              prioAct;
      logic [FIELD_W-1:0] cntInc;
      prioAct = 1'b0;
      cntInc  = '0;
      next_st = st;

      // apb: one wait state, answer registered
      next_st.pready  = apbAccess;
      next_st.pslverr = apbAccess & ~mapped;
      next_st.prdata  = '0;
      if (apbAccess) begin
         if (mcv_hit(paddr, REG_CTRL)) begin
            next_st.prdata[CTRL_AUTO_RESUME] = st.autoResume;
         end else if (mcv_hit(paddr, REG_STATUS)) begin
            next_st.prdata[ST_HELD]  = (st.pst == PS_HELD);
            next_st.prdata[ST_PAUSE] = st.pauseReq;
            next_st.prdata[ST_XON]   = st.xonReq;
            next_st.prdata[ST_PFC]   = st.pfcReq;
            next_st.prdata[ST_ACT_LSB +: PRIO_N] = st.prioPrev;
         end else if (mcv_hit(paddr, REG_LEGACY)) begin
            next_st.prdata[FIELD_W-1:0] = st.shLegacy;
         end else if (mcv_hit(paddr, REG_RXPFC)) begin
            next_st.prdata[FIELD_W-1:0] = st.shRx;
         end
      end
      if (apbDone && pwrite && mcv_hit(paddr, REG_CTRL)) begin
         next_st.autoResume = pwdata[CTRL_AUTO_RESUME];
      end

      // shadow only at an idle boundary; a frame never sees settings move under it
      if (!txFrameActive) begin
         next_st.shLegacy  = cfgLegacy;
         next_st.shQuanta  = cfgQuanta;
         next_st.shRefresh = cfgRefresh;
         next_st.shEnable  = cfgEnable;
         next_st.shRx      = cfgRx;
      end

      // done pulses clear first so a same-cycle new request still wins
      if (pauseFrameDone) begin
         if (st.pauseReq) begin
            next_st.pauseReq = 1'b0;
         end else begin
            next_st.xonReq = 1'b0;
         end
      end
      if (pfcFrameDone) begin
         next_st.pfcReq  = 1'b0;
         next_st.pfcMask = '0;
      end

      // legacy pause used as an xon/xoff interface
      case (st.pst)
         PS_IDLE: begin
            if (pauseRequest) begin
               next_st.pauseReq = 1'b1;
               next_st.pauseCnt = '0;
               next_st.pst      = PS_HELD;
            end
         end
         PS_HELD: begin
            if (!pauseRequest) begin
               next_st.pst = PS_IDLE;
               if (st.autoResume) begin
                  next_st.xonReq = 1'b1;
               end
            end else if (quantaTick) begin
               cntInc = st.pauseCnt + 16'h0001;
               if (cntInc == st.shLegacy) begin
                  next_st.pauseReq = 1'b1;
                  next_st.pauseCnt = '0;
               end else begin
                  next_st.pauseCnt = cntInc;
               end
            end
         end
         default: begin
            next_st.pst = PS_IDLE;
         end
      endcase

      // per-priority generators; the enable gates the request input
      for (int i = 0; i < PRIO_N; i++) begin
         prioAct = st.shEnable[i] & reqValid[i];
         next_st.prioPrev[i] = prioAct;
         if (prioAct && !st.prioPrev[i]) begin
            next_st.pfcReq     = 1'b1;
            next_st.pfcMask[i] = 1'b1;
            next_st.prioCnt[i] = '0;
         end else if (prioAct && quantaTick) begin
            cntInc = st.prioCnt[i] + 16'h0001;
            if (cntInc == st.shRefresh[i]) begin
               next_st.pfcReq     = 1'b1;
               next_st.pfcMask[i] = 1'b1;
               next_st.prioCnt[i] = '0;
            end else begin
               next_st.prioCnt[i] = cntInc;
            end
         end
      end
   end

   // single state register; reset takes constants only
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st            <= '0;
         st.pst        <= PS_IDLE;
         st.autoResume <= CTRL_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign pauseFrameReq   = st.pauseReq;
   assign xonFrameReq     = st.xonReq;
   assign pfcFrameReq     = st.pfcReq;
   assign pfcPriorityMask = st.pfcMask;
   assign pfcQuanta       = st.shQuanta;
   assign prdata          = st.prdata;
   assign pready          = st.pready;
   assign pslverr         = st.pslverr;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_heldTick;
      st.pst == PS_HELD && pauseRequest && quantaTick;
   endsequence

   sequence s_refreshHit;
      s_heldTick ##0 (st.pauseCnt + 16'h0001 == st.shLegacy);
   endsequence

   chk_shadow_hold: assert property (txFrameActive |=> $stable(st.shLegacy)
      && $stable(st.shRefresh) && $stable(st.shEnable))
      else $error("shadow changed during a frame");

   chk_shadow_load: assert property (!txFrameActive |=> st.shLegacy == $past(cfgLegacy))
      else $error("shadow not loaded at idle boundary");

   chk_pause_start: assert property (st.pst == PS_IDLE && pauseRequest |=>
      pauseFrameReq && st.pst == PS_HELD && st.pauseCnt == 16'h0000)
      else $error("pause request did not raise a pause frame");

   chk_pause_refresh: assert property (s_refreshHit |=> pauseFrameReq && st.pauseCnt == 16'h0000)
      else $error("pause frame not refreshed at legacy count");

   chk_xon_auto: assert property (st.pst == PS_HELD && !pauseRequest && st.autoResume
      |=> xonFrameReq && st.pst == PS_IDLE)
      else $error("resume frame missing after pause release");

   chk_xon_off: assert property (!xonFrameReq && st.pst == PS_HELD && !st.autoResume
      |=> !xonFrameReq)
      else $error("resume frame sent with option off");

   chk_p7_enable: assert property ($rose(pfcPriorityMask[PRIO_N-1]) |->
      $past(st.shEnable[PRIO_N-1]) && $past(priority7RequestValid))
      else $error("priority 7 frame without its enable");

   // the quanta carried by a pending frame must not move while that frame is on the wire
   chk_pfc_quanta: assert property (pfcFrameReq && txFrameActive |=> $stable(pfcQuanta))
      else $error("frame quanta moved during a frame");

   chk_prio_refresh: assert property (st.shEnable[0] && reqValid[0] && st.prioPrev[0]
      && quantaTick && st.prioCnt[0] + 16'h0001 == st.shRefresh[0]
      |=> pfcFrameReq && pfcPriorityMask[0])
      else $error("priority refresh frame missing");

   // frame requests stand until the transmit engine reports that frame sent;
   // dropping one early would lose a pause the link partner was never told about
   chk_pause_stand: assert property (pauseFrameReq && !pauseFrameDone |=> pauseFrameReq)
      else $error("pause frame request dropped before done");

   chk_xon_stand: assert property (xonFrameReq && !(pauseFrameDone && !pauseFrameReq)
      |=> xonFrameReq)
      else $error("resume frame request dropped before done");

   chk_pfc_stand: assert property (pfcFrameReq && !pfcFrameDone |=> pfcFrameReq)
      else $error("priority frame request dropped before done");

   chk_pause_count: assert property (st.pst == PS_HELD && pauseRequest && !quantaTick
      |=> $stable(st.pauseCnt))
      else $error("pause count moved without a quantum");

   chk_pause_release: assert property (st.pst == PS_HELD && !pauseRequest
      |=> st.pst == PS_IDLE)
      else $error("pause state not left on release");

   chk_p7_gate: assert property (!st.shEnable[PRIO_N-1] && !pfcPriorityMask[PRIO_N-1]
      |=> !pfcPriorityMask[PRIO_N-1])
      else $error("priority 7 frame raised while disabled");

   chk_prio_start: assert property (st.shEnable[0] && reqValid[0] && !st.prioPrev[0]
      |=> pfcFrameReq && pfcPriorityMask[0] && st.prioCnt[0] == 16'h0000)
      else $error("priority 2 request did not raise a frame");

   chk_p7_count: assert property (st.shEnable[PRIO_N-1] && priority7RequestValid
      && st.prioPrev[PRIO_N-1] && !quantaTick |=> $stable(st.prioCnt[PRIO_N-1]))
      else $error("priority 7 count moved without a quantum");

   chk_rx_shadow: assert property (!txFrameActive |=> st.shRx == $past(cfgRx))
      else $error("receive field shadow not loaded at idle boundary");

   generate
      if (PFC_PRESENT) begin : g_chk
         for (genvar i = 0; i < PRIO_N; i++) begin : g_field
            chk_prio_fields: assert property (!txFrameActive |=>
               st.shRefresh[i] == $past(txConfigVector[PRIO2_REFRESH_LSB + i*PRIO_STRIDE +: FIELD_W])
               && st.shQuanta[i] == $past(txConfigVector[PRIO2_QUANTA_LSB + i*PRIO_STRIDE +: FIELD_W]))
               else $error("priority field taken from wrong bits");
         end
      end
   endgenerate

   chk_apb_ready: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not after one wait state");

endmodule : mcv_tx_cfg
`default_nettype wire

// ---- tb/mcv_mac_model.sv ----
/*
 * far side model: the transmit engine that answers frame requests with done pulses.
 * assumes the block's request flags come from flops on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mcv_mac_model (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic stall,
   input  wire logic pauseFrameReq,
   input  wire logic xonFrameReq,
   input  wire logic pfcFrameReq,
   output logic      pauseFrameDone,
   output logic      pfcFrameDone,
   output logic      busy
);
   logic [1:0] kind;
   logic [2:0] cnt;
   assign busy = (kind != 2'h0);
   // one frame at a time; a spare cycle after each done so a cleared flag is not resent
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         kind           <= 2'h0;
         cnt            <= 3'h0;
         pauseFrameDone <= 1'b0;
         pfcFrameDone   <= 1'b0;
      end else begin
         pauseFrameDone <= 1'b0;
         pfcFrameDone   <= 1'b0;
         if (kind == 2'h0 && cnt == 3'h0 && !stall) begin
            if (pauseFrameReq || xonFrameReq) begin
               kind <= 2'h1;
               cnt  <= 3'h2;
            end else if (pfcFrameReq) begin
               kind <= 2'h2;
               cnt  <= 3'h2;
            end
         end else if (cnt > 3'h1) begin
            cnt <= cnt - 3'h1;
         end else if (kind != 2'h0) begin
            pauseFrameDone <= (kind == 2'h1);
            pfcFrameDone   <= (kind == 2'h2);
            kind           <= 2'h0;
            cnt            <= 3'h1;
         end else begin
            cnt <= 3'h0;
         end
      end
   end
endmodule : mcv_mac_model
`default_nettype wire

// ---- tb/mcv_tx_cfg_tb.sv ----
/*
 * self-checking bench of the transmit configuration vector block.
 * assumes the design defaults (priority flow control built in) and one 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module mcv_tx_cfg_tb
   import mcv_pkg::*;
;
   typedef struct {int p; logic en; logic [15:0] q;} mcv_row_s;
   logic clock = 1'b0, nrst = 1'b0, quantaTick = 1'b0, pauseRequest = 1'b0, hold = 1'b0;
   logic priority7RequestValid = 1'b0, stall = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [6:2] priorityRequestValid = 5'h00;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [TX_PFC_W-1:0] txv = '0, v;
   logic [RX_PFC_W-1:0] rxv = '0;
   logic busy, pauseFrameDone, pfcFrameDone, pauseFrameReq, xonFrameReq, pfcFrameReq;
   logic pready, pslverr, er;
   logic [PRIO_N-1:0] mask;
   logic [PRIO_N*FIELD_W-1:0] quanta;
   logic [PRIO_N*FIELD_W-1:0] baseQuanta;
   logic basePfc;
   int error_cnt = 0, checks = 0, cyc = 0, i;
   mcv_row_s rows[7] = '{'{7, 1'b1, 16'hA107}, '{6, 1'b1, 16'hB206}, '{5, 1'b1, 16'hC305},
      '{4, 1'b1, 16'hD404}, '{3, 1'b1, 16'hE503}, '{2, 1'b1, 16'hF602}, '{7, 1'b0, 16'h1234}};

   mcv_tx_cfg mcv_tx_cfg_inst (.clock(clock), .nrst(nrst), .txConfigVector(txv),
      .rxConfigVector(rxv), .txFrameActive(busy | hold), .quantaTick(quantaTick),
      .pauseRequest(pauseRequest), .priority7RequestValid(priority7RequestValid),
      .priorityRequestValid(priorityRequestValid), .pauseFrameDone(pauseFrameDone),
      .pfcFrameDone(pfcFrameDone), .pauseFrameReq(pauseFrameReq), .xonFrameReq(xonFrameReq),
      .pfcFrameReq(pfcFrameReq), .pfcPriorityMask(mask), .pfcQuanta(quanta), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   mcv_mac_model mcv_mac_model_inst (.clock(clock), .nrst(nrst), .stall(stall),
      .pauseFrameReq(pauseFrameReq), .xonFrameReq(xonFrameReq), .pfcFrameReq(pfcFrameReq),
      .pauseFrameDone(pauseFrameDone), .pfcFrameDone(pfcFrameDone), .busy(busy));
   // a second copy built without the option: the upper vector bits are absent
   mcv_tx_cfg #(.PFC_PRESENT(1'b0)) mcv_tx_cfg_nopfc_inst (.clock(clock), .nrst(nrst),
      .txConfigVector(txv[TX_BASE_W-1:0]), .rxConfigVector(rxv[RX_BASE_W-1:0]),
      .txFrameActive(busy | hold), .quantaTick(quantaTick), .pauseRequest(pauseRequest),
      .priority7RequestValid(priority7RequestValid),
      .priorityRequestValid(priorityRequestValid), .pauseFrameDone(pauseFrameDone),
      .pfcFrameDone(pfcFrameDone), .pauseFrameReq(), .xonFrameReq(),
      .pfcFrameReq(basePfc), .pfcPriorityMask(), .pfcQuanta(baseQuanta),
      .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(8'h00), .pwdata(32'h0),
      .prdata(), .pready(), .pslverr());

   // free running clock and a hang limit well above the expected few hundred cycles
   always #10 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cy(input int n);
      repeat (n) @(posedge clock);
   endtask : cy
   task automatic settle;
      @(negedge clock);
   endtask : settle
   task automatic req(input int p, input logic val);
      if (p == 7) priority7RequestValid <= val;
      else priorityRequestValid[p] <= val;
   endtask : req
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clock);
         quantaTick <= 1'b1;
         @(posedge clock);
         quantaTick <= 1'b0;
      end
   endtask : tick
   // request held until pready is seen high at a rising edge; data taken at that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   initial begin
      cy(5);
      nrst <= 1'b1;
      settle;
      chk("pfcFrameReq", pfcFrameReq, 32'h0);
      chk("pfcQuanta", quanta[31:0], 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      $display("test reset done");
      // each row: one priority's fields, its enable bit and its request
      foreach (rows[k]) begin
         i = rows[k].p - PRIO_LO;
         v = '0;
         v[PRIO2_QUANTA_LSB + PRIO_STRIDE*i +: FIELD_W] = rows[k].q;
         v[PRIO2_REFRESH_LSB + PRIO_STRIDE*i +: FIELD_W] = 16'h0002;
         v[PRIO_ENABLE_BIT0 + rows[k].p] = rows[k].en;
         cy(1);
         txv <= v;
         cy(2);
         settle;
         chk("pfcQuanta", quanta[FIELD_W*i +: FIELD_W], rows[k].q);
         chk("absent quanta", baseQuanta[FIELD_W*i +: FIELD_W], 32'h0);
         cy(1);
         stall <= 1'b1;
         req(rows[k].p, 1'b1);
         cy(1);
         settle;
         chk("pfcFrameReq", pfcFrameReq, rows[k].en);
         chk("pfcPriorityMask", mask[i], rows[k].en);
         chk("absent pfcFrameReq", basePfc, 32'h0);
         cy(1);
         stall <= 1'b0;
         cy(6);
         settle;
         chk("pfcFrameReq sent", pfcFrameReq, 32'h0);
         if (rows[k].en) begin
            cy(1);
            stall <= 1'b1;
            tick(1);
            settle;
            chk("pfc refresh early", pfcFrameReq, 32'h0);
            tick(1);
            settle;
            chk("pfc refresh", pfcFrameReq, 32'h1);
         end
         cy(1);
         req(rows[k].p, 1'b0);
         stall <= 1'b0;
         cy(6);
         $display("test priority %0d done", rows[k].p);
      end
      // vector change while a frame is in flight must wait for the idle boundary
      cy(1);
      hold <= 1'b1;
      cy(1);
      txv[PRIO2_QUANTA_LSB +: FIELD_W] <= 16'hBEEF;
      cy(3);
      settle;
      chk("frozen quanta", quanta[15:0], 32'h0);
      cy(1);
      hold <= 1'b0;
      cy(2);
      settle;
      chk("loaded quanta", quanta[15:0], 32'hBEEF);
      $display("test frame boundary done");
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", rd[0], 32'h1);
      cy(1);
      txv[LEGACY_REFRESH_LSB +: FIELD_W] <= 16'h0003;
      rxv[RX_PFC_LSB +: FIELD_W] <= 16'hA5C3;
      cy(2);
      apb(1'b0, REG_LEGACY, 32'h0);
      chk("legacy refresh", rd[15:0], 32'h3);
      apb(1'b0, REG_RXPFC, 32'h0);
      chk("rx upper bits", rd[15:0], 32'hA5C3);
      apb(1'b0, 8'h10, 32'h0);
      chk("pslverr", er, 32'h1);
      // held pause: first frame, refresh on the third quantum, resume frame on release
      cy(1);
      stall <= 1'b1;
      pauseRequest <= 1'b1;
      cy(1);
      settle;
      chk("pauseFrameReq", pauseFrameReq, 32'h1);
      cy(1);
      stall <= 1'b0;
      cy(6);
      settle;
      chk("pause sent", pauseFrameReq, 32'h0);
      cy(1);
      stall <= 1'b1;
      tick(2);
      settle;
      chk("pause refresh early", pauseFrameReq, 32'h0);
      tick(1);
      settle;
      chk("pause refresh", pauseFrameReq, 32'h1);
      cy(1);
      stall <= 1'b0;
      cy(6);
      pauseRequest <= 1'b0;
      stall <= 1'b1;
      cy(3);
      settle;
      chk("xonFrameReq", xonFrameReq, 32'h1);
      cy(1);
      stall <= 1'b0;
      cy(6);
      settle;
      chk("xon sent", xonFrameReq, 32'h0);
      $display("test pause done");
      // reset in mid-run drops a pending request, the shadow and the resume option
      cy(1);
      stall <= 1'b1;
      pauseRequest <= 1'b1;
      cy(2);
      settle;
      chk("pause before reset", pauseFrameReq, 32'h1);
      cy(1);
      nrst <= 1'b0;
      cy(2);
      nrst <= 1'b1;
      settle;
      chk("reset pauseFrameReq", pauseFrameReq, 32'h0);
      chk("reset quanta", quanta[15:0], 32'h0);
      apb(1'b0, REG_CTRL, 32'h0);
      chk("reset ctrl", rd, 32'h0);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : mcv_tx_cfg_tb
`default_nettype wire
